// [design/ptd_term.sv]
// Functional notes
// - Container: tag A5, length byte, sub-objects
// - Private tags, top two bits set, come last
// - Repeated tags must sit next to each other
// - Defined sub-object tags run from 80 to 8B
// - Root container always carries characteristics object
// - Power object only for application directories
// - System commands mandatory for root, optional directories
// - Environment object only for root, when supported
// - Secure transport and test objects root only
// - Repeated power and minimum clock objects accepted
// - Characteristics object: tag 80, length 01, byte
// - Bit one set: stop either level, preference
// - Bit one clear: stop only at flagged level
// - Bits one, three, four clear: never stop
// - Bits five to eight flag voltage classes
// - Bit two reserved, card drives it zero
`timescale 1ns/1ps
module ptd_term
    import ptd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    ptd_link_if.term        link,
    output logic            done_o,
    output logic            err_o,
    output logic            char_seen_o,
    output logic            stop_any_o,
    output logic            stop_high_o,
    output logic            stop_low_o,
    output logic            stop_never_o,
    output ptd_pref_t       pref_o,
    output logic [3:0]      vcls_o,
    output logic [3:0]      power_cnt_o,
    output logic [3:0]      minclk_cnt_o,
    output logic [3:0]      priv_cnt_o
);
    // Sub-object lengths are short form only
    typedef enum {
        PTD_T_TAG,
        PTD_T_LEN,
        PTD_T_STAG,
        PTD_T_SLEN,
        PTD_T_SVAL,
        PTD_T_SKIP
    } ptd_tst_t;

    ptd_tst_t   state_ff;
    logic [7:0] left_ff;
    logic [7:0] sub_left_ff;
    logic [7:0] stag_ff;
    logic [7:0] prev_tag_ff;
    logic       priv_seen_ff;
    logic [7:0] char_ff;
    logic       done_ff;
    logic       err_ff;
    logic       char_seen_ff;
    logic [3:0] power_cnt_ff;
    logic [3:0] minclk_cnt_ff;
    logic [3:0] priv_cnt_ff;
    logic       is_priv;
    logic       bad_order;
    logic       stop_any;
    logic       stop_high;
    logic       stop_low;
    logic       stop_never;
    ptd_pref_t  pref;
    logic [3:0] vcls;

    assign is_priv   = (link.data[7:6] == PTD_PRIV_MARK);
    // Defined tags after a private one, a tag below the previous one, or a tag outside 80 to 8B
    assign bad_order = !is_priv && (priv_seen_ff ||
                       (link.data < prev_tag_ff) ||
                       (link.data > PTD_TAG_LAST) ||
                       (link.data < PTD_TAG_FIRST));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff      <= PTD_T_TAG;
            left_ff       <= PTD_BYTE_RST;
            sub_left_ff   <= PTD_BYTE_RST;
            stag_ff       <= PTD_BYTE_RST;
            prev_tag_ff   <= PTD_BYTE_RST;
            priv_seen_ff  <= 1'b0;
            char_ff       <= PTD_CHAR_RST;
            done_ff       <= 1'b0;
            err_ff        <= 1'b0;
            char_seen_ff  <= 1'b0;
            power_cnt_ff  <= 4'h0;
            minclk_cnt_ff <= 4'h0;
            priv_cnt_ff   <= 4'h0;
        end else begin
            done_ff <= 1'b0;
            if (link.valid) begin
                case (state_ff)
                    PTD_T_TAG: begin
                        err_ff        <= (link.data !=
                                          PTD_TAG_TEMPLATE);
                        char_seen_ff  <= 1'b0;
                        power_cnt_ff  <= 4'h0;
                        minclk_cnt_ff <= 4'h0;
                        priv_cnt_ff   <= 4'h0;
                        priv_seen_ff  <= 1'b0;
                        prev_tag_ff   <= PTD_TAG_FIRST;
                        state_ff      <= PTD_T_LEN;
                    end
                    PTD_T_LEN: begin
                        left_ff  <= link.data;
                        state_ff <= PTD_T_STAG;
                    end
                    PTD_T_STAG: begin
                        stag_ff  <= link.data;
                        left_ff  <= left_ff - 8'h01;
                        state_ff <= PTD_T_SLEN;
                        if (is_priv) begin
                            priv_seen_ff <= 1'b1;
                            priv_cnt_ff  <= priv_cnt_ff + 4'h1;
                        end else begin
                            prev_tag_ff <= link.data;
                        end
                        if (bad_order) begin
                            err_ff <= 1'b1;
                        end
                        if (link.data == PTD_TAG_POWER) begin
                            power_cnt_ff <= power_cnt_ff + 4'h1;
                        end
                        if (link.data == PTD_TAG_MINCLK) begin
                            minclk_cnt_ff <= minclk_cnt_ff + 4'h1;
                        end
                    end
                    PTD_T_SLEN: begin
                        sub_left_ff <= link.data;
                        left_ff     <= left_ff - 8'h01;
                        if ((link.data > (left_ff - 8'h01)) ||
                            ((stag_ff == PTD_TAG_CHAR) &&
                             (link.data != PTD_LEN_CHAR))) begin
                            err_ff <= 1'b1;
                        end
                        state_ff <= (link.data == 8'h00) ? PTD_T_STAG :
                                    (stag_ff == PTD_TAG_CHAR) ? PTD_T_SVAL
                                                              : PTD_T_SKIP;
                    end
                    PTD_T_SVAL: begin
                        char_ff      <= link.data;
                        char_seen_ff <= 1'b1;
                        left_ff      <= left_ff - 8'h01;
                        sub_left_ff  <= sub_left_ff - 8'h01;
                        state_ff     <= (sub_left_ff == 8'h01) ? PTD_T_STAG
                                                               : PTD_T_SKIP;
                    end
                    PTD_T_SKIP: begin
                        left_ff     <= left_ff - 8'h01;
                        sub_left_ff <= sub_left_ff - 8'h01;
                        if (sub_left_ff == 8'h01) begin
                            state_ff <= PTD_T_STAG;
                        end
                    end
                    default: state_ff <= PTD_T_TAG;
                endcase
                if (link.last) begin
                    done_ff  <= 1'b1;
                    state_ff <= PTD_T_TAG;
                    if (state_ff == PTD_T_TAG) begin
                        err_ff <= 1'b1;
                    end
                end
            end
        end
    end

    ptd_char_decode ptd_char_decode_inst (
        .char_i       (char_ff),
        .stop_any_o   (stop_any),
        .stop_high_o  (stop_high),
        .stop_low_o   (stop_low),
        .stop_never_o (stop_never),
        .pref_o       (pref),
        .vcls_o       (vcls)
    );

    logic       stop_any_ff;
    logic       stop_high_ff;
    logic       stop_low_ff;
    logic       stop_never_ff;
    ptd_pref_t  pref_ff;
    logic [3:0] vcls_ff;
    // Safe default until a valid byte arrives: never stop
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stop_any_ff   <= 1'b0;
            stop_high_ff  <= 1'b0;
            stop_low_ff   <= 1'b0;
            stop_never_ff <= 1'b1;
            pref_ff       <= PTD_PREF_NONE;
            vcls_ff       <= 4'h0;
        end else begin
            stop_any_ff   <= stop_any & char_seen_ff;
            stop_high_ff  <= stop_high & char_seen_ff;
            stop_low_ff   <= stop_low & char_seen_ff;
            stop_never_ff <= stop_never | ~char_seen_ff;
            pref_ff       <= pref;
            vcls_ff       <= vcls;
        end
    end

    assign done_o       = done_ff;
    assign err_o        = err_ff;
    assign char_seen_o  = char_seen_ff;
    assign stop_any_o   = stop_any_ff;
    assign stop_high_o  = stop_high_ff;
    assign stop_low_o   = stop_low_ff;
    assign stop_never_o = stop_never_ff;
    assign pref_o       = pref_ff;
    assign vcls_o       = vcls_ff;
    assign power_cnt_o  = power_cnt_ff;
    assign minclk_cnt_o = minclk_cnt_ff;
    assign priv_cnt_o   = priv_cnt_ff;
endmodule : ptd_term

// [design/ptd_pkg.sv]
package ptd_pkg;
    localparam logic [7:0] PTD_TAG_TEMPLATE = 8'ha5;
    localparam logic [7:0] PTD_TAG_FIRST    = 8'h80;
    localparam logic [7:0] PTD_TAG_CHAR     = 8'h80;
    localparam logic [7:0] PTD_TAG_POWER    = 8'h81;
    localparam logic [7:0] PTD_TAG_MINCLK   = 8'h82;
    localparam logic [7:0] PTD_TAG_MAXSIZE  = 8'h86;
    localparam logic [7:0] PTD_TAG_SYSCMD   = 8'h87;
    localparam logic [7:0] PTD_TAG_ENV      = 8'h88;
    localparam logic [7:0] PTD_TAG_SECURE   = 8'h89;
    localparam logic [7:0] PTD_TAG_TSTATE   = 8'h8a;
    localparam logic [7:0] PTD_TAG_LAST     = 8'h8b;
    localparam logic [7:0] PTD_LEN_CHAR     = 8'h01;
    localparam logic [7:0] PTD_LEN_ONE      = 8'h01;
    localparam logic [1:0] PTD_PRIV_MARK    = 2'h3;
    localparam int         PTD_BIT_STOP_OK  = 0;
    localparam int         PTD_BIT_RSVD     = 1;
    localparam int         PTD_BIT_HIGH     = 2;
    localparam int         PTD_BIT_LOW      = 3;
    localparam int         PTD_BIT_VCLS     = 4;
    localparam logic [7:0] PTD_CHAR_RST     = 8'h00;
    localparam logic [7:0] PTD_BYTE_RST     = 8'h00;
    localparam int         PTD_MAX_OBJ      = 12;

    typedef enum logic [1:0] {
        PTD_FILE_ROOT,
        PTD_FILE_APP,
        PTD_FILE_DIR,
        PTD_FILE_ELEM
    } ptd_file_t;

    typedef enum logic [1:0] {
        PTD_PREF_NONE,
        PTD_PREF_HIGH,
        PTD_PREF_LOW,
        PTD_PREF_RSVD
    } ptd_pref_t;
endpackage : ptd_pkg

// [design/ptd_link_if.sv]
`timescale 1ns/1ps
interface ptd_link_if;
    logic [7:0] data;
    logic       valid;
    logic       last;
    modport card (
        output data,
        output valid,
        output last
    );
    modport term (
        input  data,
        input  valid,
        input  last
    );
endinterface : ptd_link_if

// [design/ptd_char_decode.sv]
`timescale 1ns/1ps
module ptd_char_decode
    import ptd_pkg::*;
(
    input  wire logic [7:0] char_i,
    output logic            stop_any_o,
    output logic            stop_high_o,
    output logic            stop_low_o,
    output logic            stop_never_o,
    output ptd_pref_t       pref_o,
    output logic [3:0]      vcls_o
);
    always_comb begin
        stop_any_o   = char_i[PTD_BIT_STOP_OK];
        pref_o       = ptd_pref_t'({char_i[PTD_BIT_LOW],
                                    char_i[PTD_BIT_HIGH]});
        // Reserved 11 with b1 clear grants neither level
        stop_high_o  = char_i[PTD_BIT_STOP_OK] |
                       (char_i[PTD_BIT_HIGH] &
                        ~char_i[PTD_BIT_LOW]);
        stop_low_o   = char_i[PTD_BIT_STOP_OK] |
                       (char_i[PTD_BIT_LOW] &
                        ~char_i[PTD_BIT_HIGH]);
        stop_never_o = ~char_i[PTD_BIT_STOP_OK] &
                       ~char_i[PTD_BIT_HIGH] &
                       ~char_i[PTD_BIT_LOW];
        vcls_o       = char_i[7:PTD_BIT_VCLS];
    end
endmodule : ptd_char_decode

// [design/ptd_card.sv]
`timescale 1ns/1ps
module ptd_card
    import ptd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       start_i,
    input  ptd_file_t       file_kind_i,
    input  wire logic       ber_tlv_i,
    input  wire logic [7:0] char_i,
    input  wire logic       power_en_i,
    input  wire logic [7:0] power_i,
    input  wire logic       maxsize_en_i,
    input  wire logic [7:0] maxsize_i,
    input  wire logic       syscmd_en_i,
    input  wire logic [7:0] syscmd_i,
    input  wire logic       env_en_i,
    input  wire logic [7:0] env_i,
    input  wire logic       secure_en_i,
    input  wire logic [7:0] secure_i,
    output logic            busy_o,
    ptd_link_if.card        link
);
    // Each sub-object is emitted as tag, 01, one value byte
    typedef enum {
        PTD_C_IDLE,
        PTD_C_TAG,
        PTD_C_LEN,
        PTD_C_HDR_T,
        PTD_C_HDR_L,
        PTD_C_VAL
    } ptd_cst_t;

    ptd_cst_t   state_ff;
    logic [5:0] sel_ff;
    logic [5:0] nxt_sel;
    logic [7:0] len_ff;
    logic [7:0] data_ff;
    logic       valid_ff;
    logic       last_ff;
    logic [7:0] tags [6];
    logic [7:0] vals [6];

    assign tags[0] = PTD_TAG_CHAR;
    assign tags[1] = PTD_TAG_POWER;
    assign tags[2] = PTD_TAG_MAXSIZE;
    assign tags[3] = PTD_TAG_SYSCMD;
    assign tags[4] = PTD_TAG_ENV;
    assign tags[5] = PTD_TAG_SECURE;
    assign vals[0] = {char_i[7:2], 1'b0, char_i[0]};
    assign vals[1] = power_i;
    assign vals[2] = maxsize_i;
    assign vals[3] = syscmd_i;
    assign vals[4] = env_i;
    assign vals[5] = secure_i;

    // Ascending tags keep the defined objects in order
    always_comb begin
        nxt_sel    = 6'h00;
        nxt_sel[0] = (file_kind_i == PTD_FILE_ROOT);
        nxt_sel[1] = power_en_i &
                     (file_kind_i == PTD_FILE_APP);
        nxt_sel[2] = maxsize_en_i & (file_kind_i == PTD_FILE_ELEM) &
                     ber_tlv_i;
        nxt_sel[3] = (file_kind_i == PTD_FILE_ROOT) |
                     (syscmd_en_i &
                      (file_kind_i != PTD_FILE_ELEM));
        nxt_sel[4] = env_en_i &
                     (file_kind_i == PTD_FILE_ROOT);
        nxt_sel[5] = secure_en_i &
                     (file_kind_i == PTD_FILE_ROOT);
    end

    logic [2:0] cur_ff;
    logic [2:0] nxt_cur;
    always_comb begin
        nxt_cur = 3'h6;
        for (int i = 5; i >= 0; i--) begin
            if (sel_ff[i] && 3'(i) > cur_ff) begin
                nxt_cur = 3'(i);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= PTD_C_IDLE;
            sel_ff   <= 6'h00;
            cur_ff   <= 3'h0;
            len_ff   <= PTD_BYTE_RST;
            data_ff  <= PTD_BYTE_RST;
            valid_ff <= 1'b0;
            last_ff  <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            last_ff  <= 1'b0;
            case (state_ff)
                PTD_C_IDLE: begin
                    if (start_i) begin
                        sel_ff   <= nxt_sel;
                        cur_ff   <= 3'h7;
                        len_ff   <= 8'(3 * (nxt_sel[0] + nxt_sel[1] +
                                    nxt_sel[2] + nxt_sel[3] +
                                    nxt_sel[4] + nxt_sel[5]));
                        state_ff <= PTD_C_TAG;
                    end
                end
                PTD_C_TAG: begin
                    data_ff  <= PTD_TAG_TEMPLATE;
                    valid_ff <= 1'b1;
                    cur_ff   <= 3'h0;
                    state_ff <= PTD_C_LEN;
                end
                PTD_C_LEN: begin
                    data_ff  <= len_ff;
                    valid_ff <= 1'b1;
                    last_ff  <= (len_ff == 8'h00);
                    cur_ff   <= sel_ff[0] ? 3'h0 : nxt_cur;
                    state_ff <= (len_ff == 8'h00) ? PTD_C_IDLE : PTD_C_HDR_T;
                end
                PTD_C_HDR_T: begin
                    data_ff  <= tags[cur_ff];
                    valid_ff <= 1'b1;
                    state_ff <= PTD_C_HDR_L;
                end
                PTD_C_HDR_L: begin
                    data_ff  <= PTD_LEN_ONE;
                    valid_ff <= 1'b1;
                    state_ff <= PTD_C_VAL;
                end
                PTD_C_VAL: begin
                    data_ff  <= vals[cur_ff];
                    valid_ff <= 1'b1;
                    last_ff  <= (nxt_cur == 3'h6);
                    cur_ff   <= nxt_cur;
                    state_ff <= (nxt_cur == 3'h6) ? PTD_C_IDLE : PTD_C_HDR_T;
                end
                default: state_ff <= PTD_C_IDLE;
            endcase
        end
    end

    logic busy_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff != PTD_C_IDLE) || start_i;
        end
    end

    assign busy_o     = busy_ff;
    assign link.data  = data_ff;
    assign link.valid = valid_ff;
    assign link.last  = last_ff;
endmodule : ptd_card

// [tb/ptd_link_properties.sv]
`timescale 1ns/1ps
module ptd_link_properties
    import ptd_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] data_i,
    input wire logic       valid_i,
    input wire logic       last_i
);
    logic [7:0] pos_ff;
    logic [7:0] len_ff;
    logic [7:0] tag_ff;
    logic [7:0] rel;
    logic       hdr;

    // Tag bytes sit every third byte after the length
    assign rel = pos_ff - 8'h02;
    assign hdr = valid_i && pos_ff >= 8'h02 && rel % 8'h03 == 8'h00;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_ff <= 8'h00;
        end else if (valid_i) begin
            pos_ff <= last_i ? 8'h00 : pos_ff + 8'h01;
        end
    end

    // Tag cleared per container so the first tag always climbs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            len_ff <= 8'h00;
            tag_ff <= 8'h00;
        end else if (valid_i) begin
            len_ff <= pos_ff == 8'h01 ? data_i : len_ff;
            tag_ff <= pos_ff == 8'h00 ? 8'h00 : (hdr ? data_i : tag_ff);
        end
    end

    a_container_tag: assert property (
        valid_i && pos_ff == 8'h00 |-> data_i == PTD_TAG_TEMPLATE)
        else $error("container tag wrong");
    a_len_whole_objs: assert property (
        valid_i && pos_ff == 8'h00 |=> valid_i && data_i % 8'h03 == 8'h00)
        else $error("length byte missing or not whole objects");
    a_last_at_len: assert property (
        valid_i && pos_ff >= 8'h02 |-> last_i == (pos_ff == len_ff + 8'h01))
        else $error("last flag not at container end");
    a_valid_stops: assert property (
        $fell(valid_i) |-> $past(last_i))
        else $error("frame broke off before last byte");
    a_tag_range: assert property (
        hdr |-> data_i >= PTD_TAG_FIRST && data_i <= PTD_TAG_LAST)
        else $error("tag outside defined range");
    a_tag_ascending: assert property (
        hdr |-> data_i > tag_ff)
        else $error("tag out of order");
    a_sub_len_one: assert property (
        hdr |=> valid_i && data_i == PTD_LEN_ONE)
        else $error("sub-object length not one");
    a_rsvd_bit_zero: assert property (
        hdr && data_i == PTD_TAG_CHAR |-> ##2 valid_i && !data_i[PTD_BIT_RSVD])
        else $error("reserved characteristics bit set");

    c_root_min: cover property (valid_i && pos_ff == 8'h01 && data_i == 8'h06);
    c_secure: cover property (hdr && data_i == PTD_TAG_SECURE);
    c_maxsize: cover property (hdr && data_i == PTD_TAG_MAXSIZE);
endmodule : ptd_link_properties

// [tb/test_proprietary_template_decoder.sv]
`timescale 1ns/1ps
module test_proprietary_template_decoder;
    import ptd_pkg::*;
    logic       clk_i;
    logic       rst_b_i;
    logic       start;
    ptd_file_t  kind;
    logic       ber;
    logic [7:0] chr;
    logic [4:0] en;
    logic       busy;
    logic       done;
    logic       err;
    logic       seen;
    logic       s_any;
    logic       s_high;
    logic       s_low;
    logic       s_never;
    ptd_pref_t  pref;
    logic [3:0] vcls;
    logic [3:0] pw_cnt;
    logic       done2;
    logic       err2;
    logic [3:0] pw2;
    logic [3:0] mc2;
    logic [3:0] pv2;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];
    int         n_fail;
    int         samples_checked;

    ptd_link_if link();
    ptd_link_if link2();

    ptd_card ptd_card_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start),
        .file_kind_i(kind), .ber_tlv_i(ber), .char_i(chr),
        .power_en_i(en[0]), .power_i(8'h31),
        .maxsize_en_i(en[1]), .maxsize_i(8'h46),
        .syscmd_en_i(en[2]), .syscmd_i(8'h01),
        .env_en_i(en[3]), .env_i(8'h5a),
        .secure_en_i(en[4]), .secure_i(8'h3c),
        .busy_o(busy), .link(link)
    );

    ptd_term ptd_term_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
        .done_o(done), .err_o(err), .char_seen_o(seen),
        .stop_any_o(s_any), .stop_high_o(s_high), .stop_low_o(s_low),
        .stop_never_o(s_never), .pref_o(pref), .vcls_o(vcls),
        .power_cnt_o(pw_cnt), .minclk_cnt_o(), .priv_cnt_o()
    );

    // Second terminal fed by hand-made, partly broken frames
    ptd_term ptd_term_inst_2 (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link2),
        .done_o(done2), .err_o(err2), .char_seen_o(),
        .stop_any_o(), .stop_high_o(), .stop_low_o(),
        .stop_never_o(), .pref_o(), .vcls_o(),
        .power_cnt_o(pw2), .minclk_cnt_o(mc2), .priv_cnt_o(pv2)
    );

    ptd_link_properties ptd_link_properties_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .data_i(link.data),
        .valid_i(link.valid), .last_i(link.last)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Mid-cycle sample, clear of the edge that launches each byte
    always @(negedge clk_i) begin
        if (link.valid === 1'b1) got_q.push_back(link.data);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic wait_done(input bit w);
        int n;
        n = 0;
        while ((w ? done2 : done) !== 1'b1 && n < 99) begin
            @(negedge clk_i);
            n++;
        end
        chk({7'h0, n < 99}, 8'h01);
        if (n == 99) end_sim();
    endtask : wait_done

    task automatic add(input logic [7:0] t, input logic [7:0] v);
        exp_q.push_back(t);
        exp_q.push_back(PTD_LEN_ONE);
        exp_q.push_back(v);
    endtask : add

    task automatic card_run(input logic [5:0] i);
        logic       r;
        logic       a;
        logic       e;
        logic [7:0] x;
        r = i[1:0] == 2'h0;
        a = i[1:0] == 2'h1;
        e = i[1:0] == 2'h3;
        kind = ptd_file_t'(i[1:0]);
        en = i[2] ? 5'h1f : 5'h00;
        ber = i[3];
        chr = {~i[5:2], i[5:2]};
        got_q = {};
        exp_q = {};
        // Start held two edges: the second lands while busy
        start = 1'b1;
        repeat (2) @(negedge clk_i);
        start = 1'b0;
        wait_done(1'b0);
        if (r) add(PTD_TAG_CHAR, chr & 8'hfd);
        if (a && en[0]) add(PTD_TAG_POWER, 8'h31);
        if (e && ber && en[1]) add(PTD_TAG_MAXSIZE, 8'h46);
        if (r || (!e && en[2])) add(PTD_TAG_SYSCMD, 8'h01);
        if (r && en[3]) add(PTD_TAG_ENV, 8'h5a);
        if (r && en[4]) add(PTD_TAG_SECURE, 8'h3c);
        exp_q.push_front(8'(exp_q.size()));
        exp_q.push_front(PTD_TAG_TEMPLATE);
        repeat (3) @(negedge clk_i);
        chk({7'h0, busy}, 8'h00);
        chk(8'(got_q.size()), 8'(exp_q.size()));
        foreach (got_q[k]) chk(got_q[k], exp_q[k]);
        chk({7'h0, err}, 8'h00);
        chk({4'h0, pw_cnt}, {7'h0, a && en[0]});
        chk({7'h0, seen}, {7'h0, r});
        // Bit one set grants both levels; no byte seen means never stop
        x = 8'h01;
        if (r) begin
            x = {4'h0, chr[0], chr[0] || (chr[2] && !chr[3]),
                 chr[0] || (chr[3] && !chr[2]),
                 !chr[0] && !chr[2] && !chr[3]};
        end
        chk({4'h0, s_any, s_high, s_low, s_never}, x);
        if (r) begin
            chk({4'h0, vcls}, {4'h0, chr[7:4]});
            if (chr[0]) chk({6'h0, pref}, {6'h0, chr[3:2]});
        end
    endtask : card_run

    task automatic send(input logic [7:0] b[$], input logic e);
        foreach (b[k]) begin
            link2.data = b[k];
            link2.valid = 1'b1;
            link2.last = k == b.size() - 1;
            @(negedge clk_i);
        end
        // Released bus shows the inverse, not the stale byte
        link2.data = ~link2.data;
        link2.valid = 1'b0;
        link2.last = 1'b0;
        wait_done(1'b1);
        chk({7'h0, err2}, {7'h0, e});
        // Idle edge so the next frame never reassigns in this step
        @(negedge clk_i);
    endtask : send

    initial begin
        n_fail = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        start = 1'b0;
        kind = PTD_FILE_ROOT;
        ber = 1'b0;
        chr = 8'h00;
        en = 5'h00;
        link2.data = 8'h00;
        link2.valid = 1'b0;
        link2.last = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        for (int i = 0; i < 64; i++) card_run(6'(i));
        $display("test card done");
        send('{8'ha5, 8'h0f, 8'h81, 8'h01, 8'h11,
               8'h81, 8'h01, 8'h12, 8'h82, 8'h01, 8'h21,
               8'h82, 8'h01, 8'h22, 8'hc1, 8'h01, 8'h77}, 1'b0);
        chk({4'h0, pw2}, 8'h02);
        chk({4'h0, mc2}, 8'h02);
        chk({4'h0, pv2}, 8'h01);
        send('{8'ha5, 8'h04, 8'h80, 8'h02, 8'h01, 8'h00}, 1'b1);
        send('{8'ha5, 8'h03, 8'h87, 8'h05, 8'h00}, 1'b1);
        send('{8'ha5, 8'h06, 8'hc1, 8'h01, 8'h00, 8'h81,
               8'h01, 8'h00}, 1'b1);
        send('{8'ha5, 8'h06, 8'h87, 8'h01, 8'h00, 8'h81,
               8'h01, 8'h00}, 1'b1);
        send('{8'ha5, 8'h03, 8'h8c, 8'h01, 8'h00}, 1'b1);
        send('{8'ha5, 8'h00}, 1'b0);
        $display("test term done");
        end_sim();
    end
endmodule : test_proprietary_template_decoder
